// File: rtc_cal_alarm_pkg.sv
// constants, register map and field layout for the calibration and alarm block
// assumes a single clock domain and the plain register port of the top module
package rtc_cal_alarm_pkg;

   // register indices on the plain port
   localparam logic [2:0] REG_CAL_CONFIG = 3'h0;
   localparam logic [2:0] REG_ALARM_CFG  = 3'h1;
   localparam logic [2:0] REG_ALARM_MD   = 3'h2;
   localparam logic [2:0] REG_ALARM_WH   = 3'h3;
   localparam logic [2:0] REG_ALARM_MS   = 3'h4;
   localparam logic [2:0] REG_STATUS     = 3'h5;

   // calibration / control register fields
   localparam int CAL_LSB       = 0;
   localparam int CAL_W         = 8;
   localparam int CAL_SCALE_SH  = 2;
   localparam int WREN_BIT      = 8;
   localparam int TIMER_ON_BIT  = 15;

   // alarm configuration fields
   localparam int ALM_EN_BIT    = 15;
   localparam int ENDLESS_REPEAT_BIT_BIT     = 14;
   localparam int MASK_MSB      = 13;
   localparam int MASK_LSB      = 10;
   localparam int RPT_MSB       = 7;

   // status fields
   localparam int ST_PULSE_BIT  = 0;
   localparam int ST_SYNC_BIT   = 1;
   localparam int ST_BUSY_BIT   = 2;

   // write masks of the alarm value registers (unimplemented bits read zero)
   localparam logic [15:0] MD_WMASK = 16'h1F3F;
   localparam logic [15:0] WH_WMASK = 16'h073F;
   localparam logic [15:0] MS_WMASK = 16'h7F7F;

   localparam logic [15:0] CAL_RESET  = 16'h0000;
   localparam logic [15:0] CFG_RESET  = 16'h0000;
   localparam logic [7:0]  RPT_WRAP   = 8'hFF;
   localparam logic [7:0]  RPT_LAST   = 8'h00;

   // alarm interval codes
   typedef enum logic [3:0] {
      MASK_HALF_SEC = 4'h0,
      MASK_SEC      = 4'h1,
      MASK_TEN_SEC  = 4'h2,
      MASK_MIN      = 4'h3,
      MASK_TEN_MIN  = 4'h4,
      MASK_HOUR     = 4'h5,
      MASK_DAY      = 4'h6,
      MASK_WEEK     = 4'h7,
      MASK_MONTH    = 4'h8,
      MASK_YEAR     = 4'h9
   } alarm_mask_t;

   // calibration sequencer states, gray along idle -> load -> run
   typedef enum logic [1:0] {
      CAL_IDLE = 2'b00,
      CAL_LOAD = 2'b01,
      CAL_RUN  = 2'b11
   } cal_state_t;

endpackage : rtc_cal_alarm_pkg

// File: rtc_alarm_match.sv
// compares the running time digits with the stored alarm digits under the mask
// assumes tick pulses and BCD time come from the timekeeping counters outside
`timescale 1ns/1ps
module rtc_alarm_match
   import rtc_cal_alarm_pkg::*;
(
   // mask and stored digits
   input  wire logic [3:0]  mask,
   input  wire logic [15:0] alarm_md,
   input  wire logic [15:0] alarm_wh,
   input  wire logic [15:0] alarm_ms,
   // live time and ticks
   input  wire logic [15:0] time_md,
   input  wire logic [15:0] time_wh,
   input  wire logic [15:0] time_ms,
   input  wire logic        half_sec_tick,
   input  wire logic        sec_tick,
   // result
   output      logic        hit
);
   wire sec_one  = alarm_ms[3:0]   == time_ms[3:0];
   wire sec_ten  = alarm_ms[6:4]   == time_ms[6:4];
   wire min_one  = alarm_ms[11:8]  == time_ms[11:8];
   wire min_ten  = alarm_ms[14:12] == time_ms[14:12];
   wire hr_all   = alarm_wh[5:0]   == time_wh[5:0];
   wire weekday_digit_eq  = alarm_wh[10:8]  == time_wh[10:8];
   wire day_eq   = alarm_md[5:0]   == time_md[5:0];
   wire mth_eq   = alarm_md[12:8]  == time_md[12:8];
   wire t_sec    = sec_one;
   wire t_tsec   = t_sec & sec_ten;
   wire t_min    = t_tsec & min_one;
   wire t_tmin   = t_min & min_ten;
   wire t_time   = t_tmin & hr_all;

   // from ten seconds to day each interval widens the compared digits; week, month and year add weekday, day, and day with month
   always_comb
   begin
      unique case (mask)
         MASK_HALF_SEC: hit = half_sec_tick;
         MASK_SEC:      hit = sec_tick;
         MASK_TEN_SEC:  hit = sec_tick & sec_one;
         MASK_MIN:      hit = sec_tick & t_tsec;
         MASK_TEN_MIN:  hit = sec_tick & t_min;
         MASK_HOUR:     hit = sec_tick & t_tmin;
         MASK_DAY:      hit = sec_tick & t_time;
         MASK_WEEK:     hit = sec_tick & t_time & weekday_digit_eq;
         MASK_MONTH:    hit = sec_tick & t_time & day_eq;
         MASK_YEAR:     hit = sec_tick & t_time & day_eq & mth_eq;
         default:       hit = 1'b0;
      endcase
   end
endmodule : rtc_alarm_match

// File: rtc_cal_step.sv
// turns the signed calibration byte into a per-minute pulse correction
// assumes minute_tick is one cycle long and the counter honours adj pulses
`timescale 1ns/1ps
module rtc_cal_step
   import rtc_cal_alarm_pkg::*;
(
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             reset_n,
   // control
   input  wire logic             minute_tick,
   input  wire logic [CAL_W-1:0] cal_value,
   // correction pulses and busy flag
   output      logic             add_pulse,
   output      logic             drop_pulse,
   output      logic             busy
);
   cal_state_t  state;
   cal_state_t  next_state;
   logic [9:0]  count;
   logic        negative;

   // magnitude of value times four
   wire  [7:0]  mag   = cal_value[CAL_W-1] ? 8'(-cal_value) : cal_value;
   wire  [9:0]  steps = {mag, 2'b00};

   always_comb
   begin
      next_state = state;
      unique case (state)
         CAL_IDLE: if (minute_tick && mag != 8'h00) next_state = CAL_LOAD;
         CAL_LOAD: next_state = CAL_RUN;
         CAL_RUN:  if (count == 10'h001) next_state = CAL_IDLE;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         state    <= CAL_IDLE;
         count    <= 10'h000;
         negative <= 1'b0;
      end
      else
      begin
         state <= next_state;
         if (state == CAL_IDLE && minute_tick)
         begin
            count    <= steps;
            negative <= cal_value[CAL_W-1];
         end
         else if (state == CAL_RUN)
            count <= count - 10'h001;
      end
   end

   // negative removes pulses, positive adds them
   assign add_pulse  = state == CAL_RUN && !negative;
   assign drop_pulse = state == CAL_RUN && negative;
   assign busy       = state != CAL_IDLE;
endmodule : rtc_cal_step

// File: rtc_cal_alarm.sv
// calibration and alarm logic of the real-time clock/calendar
// assumes time digits and tick pulses come from the counters outside, synchronous to mclk
//
// Summary of operation
// - each minute while timer-on bit 15 is set, the signed calibration byte times four corrects the counter
// - one calibration step is four pulses; negative values remove pulses
// - alarm enable bit 15 arms the alarm; hardware clears it after last alarm
// - mask field bits 13:10 selects which digits must match
// - mask codes pick half second through yearly intervals
// - day alarms compare the time digits; week, month and year add weekday, day, and day with month
// - zero repeat count without endless bit gives a single alarm
// - repeat count of FFh gives up to 255 further alarms
// - each alarm decrements count; at 00 one last alarm then disable
// - endless bit wraps the count from 00 to FF instead of disabling
// - an interrupt request pulses at every alarm event
// - the alarm pulse output toggles on each alarm, synchronous to mclk
// - alarm value registers take writes only while write enable is one
// - weekday is a 3-bit digit, hours a 2-bit tens and 4-bit ones
`timescale 1ns/1ps
module rtc_cal_alarm
   import rtc_cal_alarm_pkg::*;
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        reset_n,
   // register port
   input  wire logic [2:0]  reg_addr,
   input  wire logic [15:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output      logic [15:0] reg_rdata,
   // from the timekeeping counters
   input  wire logic        half_sec_tick,
   input  wire logic        sec_tick,
   input  wire logic        minute_tick,
   input  wire logic        timer_sync_flag,
   input  wire logic [15:0] time_md,
   input  wire logic [15:0] time_wh,
   input  wire logic [15:0] time_ms,
   // to the timekeeping counters and the system
   output      logic        timer_on,
   output      logic        cal_add_pulse,
   output      logic        cal_drop_pulse,
   output      logic        alarm_irq,
   output      logic        alarm_pulse
);
   // ==========================================================
   // registers
   logic [15:0] clock_config_calibration;
   logic        alarm_enable_bit;
   logic        endless_repeat_bit;
   logic [3:0]  alarm_mask_field;
   logic [7:0]  repeat_count;
   logic [15:0] alarm_value_md;
   logic [15:0] alarm_value_wh;
   logic [15:0] alarm_value_ms;
   logic [15:0] next_rdata;

   // ==========================================================
   // decode
   wire wr_cal  = reg_write && reg_addr == REG_CAL_CONFIG;
   wire wr_cfg  = reg_write && reg_addr == REG_ALARM_CFG;
   wire clock_write_enable = clock_config_calibration[WREN_BIT];
   wire wr_md   = reg_write && reg_addr == REG_ALARM_MD && clock_write_enable;
   wire wr_wh   = reg_write && reg_addr == REG_ALARM_WH && clock_write_enable;
   wire wr_ms   = reg_write && reg_addr == REG_ALARM_MS && clock_write_enable;

   wire [15:0] alarm_config_repeat = {alarm_enable_bit, endless_repeat_bit,
                                      alarm_mask_field, 2'b00, repeat_count};

   // ==========================================================
   // calibration sequencer
   logic cal_add;
   logic cal_drop;
   logic cal_busy;

   rtc_cal_step u_cal_step (
      .mclk        (mclk),
      .reset_n     (reset_n),
      .minute_tick (minute_tick & clock_config_calibration[TIMER_ON_BIT]),
      .cal_value   (clock_config_calibration[CAL_LSB +: CAL_W]),
      .add_pulse   (cal_add),
      .drop_pulse  (cal_drop),
      .busy        (cal_busy)
   );

   // ==========================================================
   // alarm compare
   logic match_hit;

   rtc_alarm_match u_match (
      .mask          (alarm_mask_field),
      .alarm_md      (alarm_value_md),
      .alarm_wh      (alarm_value_wh),
      .alarm_ms      (alarm_value_ms),
      .time_md       (time_md),
      .time_wh       (time_wh),
      .time_ms       (time_ms),
      .half_sec_tick (half_sec_tick),
      .sec_tick      (sec_tick),
      .hit           (match_hit)
   );

   wire fire      = alarm_enable_bit && match_hit;
   wire last_one  = repeat_count == RPT_LAST && !endless_repeat_bit;

   // ==========================================================
   // read mux
   always_comb
   begin
      unique case (reg_addr)
         REG_CAL_CONFIG: next_rdata = clock_config_calibration;
         REG_ALARM_CFG:  next_rdata = alarm_config_repeat;
         REG_ALARM_MD:   next_rdata = alarm_value_md;
         REG_ALARM_WH:   next_rdata = alarm_value_wh;
         REG_ALARM_MS:   next_rdata = alarm_value_ms;
         REG_STATUS:     next_rdata = {13'h0000, cal_busy, timer_sync_flag, alarm_pulse};
         default:        next_rdata = 16'h0000;
      endcase
   end

   // ==========================================================
   // register and alarm state
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
      begin
         clock_config_calibration <= CAL_RESET;
         alarm_enable_bit         <= 1'b0;
         endless_repeat_bit       <= 1'b0;
         alarm_mask_field         <= 4'h0;
         repeat_count             <= 8'h00;
         alarm_value_md           <= 16'h0000;
         alarm_value_wh           <= 16'h0000;
         alarm_value_ms           <= 16'h0000;
         reg_rdata                <= 16'h0000;
         alarm_irq                <= 1'b0;
         alarm_pulse              <= 1'b0;
         timer_on                 <= 1'b0;
         cal_add_pulse            <= 1'b0;
         cal_drop_pulse           <= 1'b0;
      end
      else
      begin
         reg_rdata      <= reg_read ? next_rdata : 16'h0000;
         timer_on       <= clock_config_calibration[TIMER_ON_BIT];
         cal_add_pulse  <= cal_add;
         cal_drop_pulse <= cal_drop;
         alarm_irq      <= fire;
         if (fire)
            alarm_pulse <= !alarm_pulse;
         if (wr_cal)
            clock_config_calibration <= reg_wdata;
         if (wr_md)
            alarm_value_md <= reg_wdata & MD_WMASK;
         if (wr_wh)
            alarm_value_wh <= reg_wdata & WH_WMASK;
         if (wr_ms)
            alarm_value_ms <= reg_wdata & MS_WMASK;
         if (wr_cfg)
         begin
            alarm_enable_bit   <= reg_wdata[ALM_EN_BIT];
            endless_repeat_bit <= reg_wdata[ENDLESS_REPEAT_BIT_BIT];
            alarm_mask_field   <= reg_wdata[MASK_MSB:MASK_LSB];
            repeat_count       <= reg_wdata[RPT_MSB:0];
         end
         // an alarm in the same cycle as a config write wins
         if (fire)
         begin
            if (last_one)
               alarm_enable_bit <= 1'b0;
            else if (repeat_count == RPT_LAST)
               repeat_count <= RPT_WRAP;
            else
               repeat_count <= repeat_count - 8'h01;
         end
      end
   end
endmodule : rtc_cal_alarm

// File: rtc_cal_alarm_monitor.sv
// port checker of the calibration and alarm block
// assumes one clock, mclk, and the bind at the foot of this file
`timescale 1ns/1ps
module rtc_cal_alarm_monitor
   import rtc_cal_alarm_pkg::*;
(
   // clock, reset and register port
   input wire logic        mclk,
   input wire logic        reset_n,
   input wire logic [2:0]  reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [15:0] reg_rdata,
   // ticks and outputs
   input wire logic        half_sec_tick,
   input wire logic        sec_tick,
   input wire logic        minute_tick,
   input wire logic        timer_on,
   input wire logic        cal_add_pulse,
   input wire logic        cal_drop_pulse,
   input wire logic        alarm_irq,
   input wire logic        alarm_pulse
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // ==========================================================
   // shadow of the calibration byte and length of a pulse run
   logic [7:0] cal_sh;
   logic [9:0] run_len;
   wire        pulsing = cal_add_pulse | cal_drop_pulse;
   wire  [7:0] cal_mag = cal_sh[7] ? 8'h00 - cal_sh : cal_sh;
   always_ff @(posedge mclk)
   begin
      if (!reset_n)
         cal_sh <= 8'h00;
      else if (reg_write && reg_addr == REG_CAL_CONFIG)
         cal_sh <= reg_wdata[7:0];
   end
   // restarted by the tick, so a run is measured whole
   always_ff @(posedge mclk)
   begin
      if (!reset_n || (minute_tick && !pulsing))
         run_len <= 10'h000;
      else if (pulsing)
         run_len <= run_len + 10'h001;
   end
   // ==========================================================
   // assertions
   a_cal_exclusive: assert property (!(cal_add_pulse && cal_drop_pulse))
      else $error("add and drop pulses together");
   a_cal_start: assert property (minute_tick && timer_on && cal_sh != 8'h00 && !pulsing
      |-> ##3 (cal_sh[7] ? cal_drop_pulse : cal_add_pulse)) else $error("correction late");
   a_cal_count: assert property ($fell(pulsing) |-> run_len == {cal_mag, 2'b00})
      else $error("wrong correction length");
   a_irq_single: assert property (alarm_irq |=> !alarm_irq)
      else $error("interrupt longer than one cycle");
   a_irq_cause: assert property (alarm_irq |-> $past(sec_tick | half_sec_tick))
      else $error("alarm without a tick");
   a_pulse_toggle: assert property (alarm_irq |-> alarm_pulse != $past(alarm_pulse))
      else $error("alarm pulse did not toggle");
   a_pulse_hold: assert property (!alarm_irq |-> $stable(alarm_pulse))
      else $error("alarm pulse moved without alarm");
   // the output copy lags the register by one flop, so it shows two edges after the write
   a_timer_copy: assert property ($past(reg_write && reg_addr == REG_CAL_CONFIG, 2)
      |-> timer_on == $past(reg_wdata[TIMER_ON_BIT], 2)) else $error("timer enable not copied");
   a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
      else $error("read data outside read slot");
   c_drop: cover property ($fell(cal_drop_pulse));
   c_add: cover property ($fell(cal_add_pulse));
   c_repeat: cover property (alarm_irq ##[1:8] alarm_irq);
endmodule : rtc_cal_alarm_monitor

bind rtc_cal_alarm rtc_cal_alarm_monitor i_mon (.mclk, .reset_n, .reg_addr, .reg_wdata,
   .reg_write, .reg_read, .reg_rdata, .half_sec_tick, .sec_tick, .minute_tick, .timer_on,
   .cal_add_pulse, .cal_drop_pulse, .alarm_irq, .alarm_pulse);

// File: rtc_cal_alarm_tb_top.sv
// self-checking bench of the calibration and alarm block
// assumes the monitor is bound from its own file
`timescale 1ns/1ps
module rtc_cal_alarm_tb_top;
   import rtc_cal_alarm_pkg::*;
   // ==========================================================
   // stimulus and observation
   logic        mclk = 0, reset_n = 0, reg_write = 0, reg_read = 0, timer_sync_flag = 0;
   logic        half_sec_tick = 0, sec_tick = 0, minute_tick = 0;
   logic [2:0]  reg_addr = 0;
   logic [15:0] reg_wdata = 0, time_md = 16'h0115, time_wh = 16'h0312, time_ms = 16'h3045;
   logic [15:0] reg_rdata;
   logic        timer_on, cal_add_pulse, cal_drop_pulse, alarm_irq, alarm_pulse;
   logic [7:0]  cv [4] = '{8'hFE, 8'h02, 8'h80, 8'h7F};
   int          err_count = 0, n_checks = 0, n_irq = 0, n_add = 0, n_drop = 0, b, c, v;
   always #2.5 mclk = ~mclk;
   always @(posedge mclk)
   begin
      n_irq += (alarm_irq === 1'b1);
      n_add += (cal_add_pulse === 1'b1);
      n_drop += (cal_drop_pulse === 1'b1);
   end
   rtc_cal_alarm i_dut (.mclk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
      .reg_rdata, .half_sec_tick, .sec_tick, .minute_tick, .timer_sync_flag, .time_md,
      .time_wh, .time_ms, .timer_on, .cal_add_pulse, .cal_drop_pulse, .alarm_irq,
      .alarm_pulse);
   // ==========================================================
   // tasks
   task automatic chk(input string n, input logic [15:0] e, g);
      n_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge mclk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_write <= 1'b0;
   endtask : wr
   task automatic rd(input logic [2:0] a, input logic [15:0] e);
      @(posedge mclk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_read <= 1'b0;
      #1 chk($sformatf("register %0d", a), e, reg_rdata);
   endtask : rd
   // one tick pulse, then one more edge so the alarm response is counted
   task automatic tk(input logic h, s, m);
      @(posedge mclk);
      half_sec_tick <= h;
      sec_tick <= s;
      minute_tick <= m;
      @(posedge mclk);
      half_sec_tick <= 1'b0;
      sec_tick <= 1'b0;
      minute_tick <= 1'b0;
      @(posedge mclk);
      #1;
   endtask : tk
   task automatic al(input logic [3:0] m, input logic [15:0] md, wh, ms, input int e);
      time_md <= md;
      time_wh <= wh;
      time_ms <= ms;
      b = n_irq;
      wr(REG_ALARM_CFG, {2'b10, m, 10'h000});
      tk(1'b1, 1'b1, 1'b0);
      chk($sformatf("alarms of mask %0d", m), 16'(e), 16'(n_irq - b));
      wr(REG_ALARM_CFG, 16'h0000);
   endtask : al
   task automatic final_report;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report
   // ==========================================================
   // watchdog, far beyond the few thousand cycles of the tests
   initial
   begin
      repeat (30000) @(posedge mclk);
      err_count++;
      final_report();
   end
   // ==========================================================
   // test sequence
   initial
   begin
      repeat (2) @(posedge mclk);
      reset_n <= 1'b1;
      rd(REG_CAL_CONFIG, CAL_RESET);
      rd(REG_ALARM_CFG, CFG_RESET);
      wr(REG_ALARM_MS, 16'h3045);
      rd(REG_ALARM_MS, 16'h0000);
      wr(REG_CAL_CONFIG, 16'h0100);
      wr(REG_ALARM_MS, 16'hFFFF);
      rd(REG_ALARM_MS, MS_WMASK);
      wr(REG_ALARM_WH, 16'hFFFF);
      rd(REG_ALARM_WH, WH_WMASK);
      wr(REG_ALARM_MD, 16'hFFFF);
      rd(REG_ALARM_MD, MD_WMASK);
      wr(REG_ALARM_MS, 16'h3045);
      wr(REG_ALARM_WH, 16'h0312);
      wr(REG_ALARM_MD, 16'h0115);
      // the byte goes in together with the timer enable, while the timer is still off
      for (int k = 0; k < 4; k++)
      begin
         v = int'($signed(cv[k]));
         b = n_add;
         c = n_drop;
         wr(REG_CAL_CONFIG, {8'h81, cv[k]});
         tk(1'b0, 1'b0, 1'b1);
         chk("timer on", 16'd1, 16'(timer_on));
         rd(REG_STATUS, 16'h0004);
         repeat (520) @(posedge mclk);
         chk("added pulses", 16'(v > 0 ? 4 * v : 0), 16'(n_add - b));
         chk("dropped pulses", 16'(v < 0 ? -4 * v : 0), 16'(n_drop - c));
         wr(REG_CAL_CONFIG, {8'h01, cv[k]});
      end
      b = n_add;
      c = n_drop;
      tk(1'b0, 1'b0, 1'b1);
      chk("timer off", 16'd0, 16'(timer_on));
      repeat (8) @(posedge mclk);
      chk("pulses with timer off", 16'd0, 16'(n_add - b + n_drop - c));
      wr(REG_CAL_CONFIG, 16'h8100);
      b = n_irq;
      wr(REG_ALARM_CFG, 16'h8C00);
      tk(1'b0, 1'b1, 1'b0);
      tk(1'b0, 1'b1, 1'b0);
      chk("one-shot alarms", 16'd1, 16'(n_irq - b));
      chk("alarm pulse", 16'd1, 16'(alarm_pulse));
      rd(REG_ALARM_CFG, 16'h0C00);
      b = n_irq;
      wr(REG_ALARM_CFG, 16'h8402);
      repeat (4) tk(1'b0, 1'b1, 1'b0);
      chk("counted alarms", 16'd3, 16'(n_irq - b));
      rd(REG_ALARM_CFG, 16'h0400);
      b = n_irq;
      wr(REG_ALARM_CFG, 16'h84FF);
      repeat (257) tk(1'b0, 1'b1, 1'b0);
      chk("full count alarms", 16'd256, 16'(n_irq - b));
      wr(REG_ALARM_CFG, 16'hC000);
      tk(1'b1, 1'b0, 1'b0);
      rd(REG_ALARM_CFG, 16'hC0FF);
      tk(1'b1, 1'b0, 1'b0);
      rd(REG_ALARM_CFG, 16'hC0FE);
      wr(REG_ALARM_CFG, 16'h0000);
      timer_sync_flag <= 1'b1;
      rd(REG_STATUS, 16'h0002);
      // the sync flag only shows in status bit 1; configuration writes ignore it
      @(posedge mclk);
      timer_sync_flag <= 1'b0;
      rd(3'h6, 16'h0000);
      for (int k = 0; k < 11; k++)
         al(4'(k), 16'h0115, 16'h0312, 16'h3045, k < 10);
      al(4'h9, 16'h0215, 16'h0312, 16'h3045, 0);
      al(4'h8, 16'h0215, 16'h0312, 16'h3045, 1);
      al(4'h8, 16'h0116, 16'h0312, 16'h3045, 0);
      al(4'h7, 16'h0116, 16'h0312, 16'h3045, 1);
      al(4'h7, 16'h0115, 16'h0412, 16'h3045, 0);
      al(4'h6, 16'h0115, 16'h0412, 16'h3045, 1);
      al(4'h6, 16'h0115, 16'h0313, 16'h3045, 0);
      al(4'h5, 16'h0115, 16'h0313, 16'h3045, 1);
      al(4'h4, 16'h0115, 16'h0312, 16'h3145, 0);
      al(4'h3, 16'h0115, 16'h0312, 16'h3145, 1);
      al(4'h2, 16'h0115, 16'h0312, 16'h3046, 0);
      al(4'h1, 16'h0115, 16'h0312, 16'h3046, 1);
      final_report();
   end
endmodule : rtc_cal_alarm_tb_top
